/* File: design/wdrt_timer.sv */
// Supervision timer with AXI4-Lite control, lock and forced controller reset
`timescale 1ns/1ps
`include "wdrt_regs.svh"
module wdrt_timer #(
	parameter int CNT_W  = 20,
	parameter int CLK_HZ = `WDRT_CLK_HZ,
	parameter int LFO_HZ = `WDRT_LFO_HZ
) (
	input  wire logic                    ref_clk,
	input  wire logic                    arst_n,
	input  wire logic                    lowFreqOsc,
	input  wire logic [`WDRT_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [`WDRT_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	output logic                         forceReset,
	output logic                         pcLoad,
	output logic [15:0]                  bootAddr,
	output logic                         extRstPinOut,
	output logic                         extRstPinOe
);

	localparam int PULSE_A = `WDRT_PULSE_CYC;
	localparam int SHIFT_TOP = `WDRT_SEL_SHIFT_MUL * `WDRT_SEL_MAX + `WDRT_SEL_SHIFT_BASE;
	localparam int FIRE_TAIL = PULSE_A - 7;

	// Sync plus edge detect need several system clocks per oscillator period
	if (CNT_W < SHIFT_TOP || CNT_W > `WDRT_STAT_RUN_BIT) begin : g_bad_cnt_w
		$error("CNT_W must cover the longest interval and fit the status field");
	end
	if (CLK_HZ < 4 * LFO_HZ) begin : g_bad_clk
		$error("System clock too slow to sample the oscillator");
	end

	// Terminal count of the selected interval: 4^sel times 64 ticks
	function automatic logic [CNT_W-1:0] wdrtLimit(input logic [`WDRT_SEL_W-1:0] sel);
		logic [CNT_W:0] one;
		one = (CNT_W+1)'(1);
		return CNT_W'((one << (`WDRT_SEL_SHIFT_MUL * sel + `WDRT_SEL_SHIFT_BASE)) - (CNT_W+1)'(1));
	endfunction : wdrtLimit

	logic                        lfoTick;
	wdrt_pkg::wdrt_state_type    state_reg;
	wdrt_pkg::wdrt_state_type    state_next;
	logic [CNT_W-1:0]            count_reg;
	logic                        enable_reg;
	logic                        lock_reg;
	logic [`WDRT_SEL_W-1:0]      sel_reg;
	logic [7:0]                  pulse_reg;
	logic                        awHeld_reg;
	logic                        wHeld_reg;
	logic [`WDRT_ADDR_W-1:0]     awAddr_reg;
	logic [31:0]                 wData_reg;
	logic [3:0]                  wStrb_reg;
	logic                        wrFire;
	logic                        ctrlWr;
	logic                        restartWr;
	logic                        overflow;

	wdrt_tick_sync u_tick (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.lowFreqOsc(lowFreqOsc),
		.lfoTick   (lfoTick)
	);

	// Write side: address and data taken in either order, answer after both
	assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
	assign wrFire        = awHeld_reg && wHeld_reg && !s_axi_bvalid;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			awHeld_reg <= 1'b0;
			wHeld_reg  <= 1'b0;
			awAddr_reg <= '0;
			wData_reg  <= 32'h0000_0000;
			wStrb_reg  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end else if (wrFire) begin
				awHeld_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end else if (wrFire) begin
				wHeld_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `WDRT_RESP_OKAY;
		end else if (wrFire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awAddr_reg == `WDRT_OFF_CTRL || awAddr_reg == `WDRT_OFF_RESTART)
				? `WDRT_RESP_OKAY : `WDRT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	assign ctrlWr    = wrFire && awAddr_reg == `WDRT_OFF_CTRL && wStrb_reg[0];
	assign restartWr = wrFire && awAddr_reg == `WDRT_OFF_RESTART;

	// Read side: one outstanding read, data registered
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `WDRT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `WDRT_RESP_OKAY;
			s_axi_rdata  <= 32'h0000_0000;
			case (s_axi_araddr)
				`WDRT_OFF_CTRL: begin
					s_axi_rdata[`WDRT_CTRL_EN_BIT]                    <= enable_reg;
					s_axi_rdata[`WDRT_CTRL_LOCK_BIT]                  <= lock_reg;
					s_axi_rdata[`WDRT_CTRL_SEL_HI:`WDRT_CTRL_SEL_LO]  <= sel_reg;
				end
				`WDRT_OFF_RESTART: begin
					s_axi_rdata <= 32'h0000_0000;
				end
				`WDRT_OFF_STATUS: begin
					s_axi_rdata[CNT_W-1:0]            <= count_reg;
					s_axi_rdata[`WDRT_STAT_RUN_BIT]   <= state_reg == wdrt_pkg::WDRT_ST_COUNT;
					s_axi_rdata[`WDRT_STAT_LOCK_BIT]  <= lock_reg;
					s_axi_rdata[`WDRT_STAT_FIRE_BIT]  <= forceReset;
				end
				default: begin
					s_axi_rresp <= `WDRT_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Configuration; defaults come back whenever the vector state is passed
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			enable_reg <= 1'b1;
			lock_reg   <= 1'b0;
			sel_reg    <= `WDRT_SEL_MAX;
		end else if (state_reg == wdrt_pkg::WDRT_ST_VECTOR) begin
			enable_reg <= 1'b1;
			lock_reg   <= 1'b0;
			sel_reg    <= `WDRT_SEL_MAX;
		end else if (ctrlWr && !lock_reg) begin
			enable_reg <= wData_reg[`WDRT_CTRL_EN_BIT] | wData_reg[`WDRT_CTRL_LOCK_BIT];
			lock_reg   <= wData_reg[`WDRT_CTRL_LOCK_BIT];
			sel_reg    <= wData_reg[`WDRT_CTRL_SEL_HI:`WDRT_CTRL_SEL_LO];
		end
	end

	assign overflow = state_reg == wdrt_pkg::WDRT_ST_COUNT && lfoTick && count_reg >= wdrtLimit(sel_reg);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			wdrt_pkg::WDRT_ST_VECTOR: state_next = wdrt_pkg::WDRT_ST_COUNT;
			wdrt_pkg::WDRT_ST_COUNT: begin
				if (overflow && !restartWr)
					state_next = wdrt_pkg::WDRT_ST_FIRE;
				else if (!enable_reg)
					state_next = wdrt_pkg::WDRT_ST_IDLE;
			end
			wdrt_pkg::WDRT_ST_IDLE: begin
				if (enable_reg)
					state_next = wdrt_pkg::WDRT_ST_COUNT;
			end
			wdrt_pkg::WDRT_ST_FIRE: begin
				if (pulse_reg == 8'h01)
					state_next = wdrt_pkg::WDRT_ST_VECTOR;
			end
			default: state_next = wdrt_pkg::WDRT_ST_VECTOR;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			state_reg <= wdrt_pkg::WDRT_ST_VECTOR;
		else
			state_reg <= state_next;
	end

	// Restart beats a coinciding tick, so a late restart is never lost
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= '0;
		end else if (restartWr || state_reg != wdrt_pkg::WDRT_ST_COUNT) begin
			count_reg <= '0;
		end else if (lfoTick) begin
			count_reg <= count_reg + CNT_W'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pulse_reg  <= 8'h00;
			forceReset <= 1'b0;
		end else if (state_reg == wdrt_pkg::WDRT_ST_COUNT && state_next == wdrt_pkg::WDRT_ST_FIRE) begin
			pulse_reg  <= 8'(PULSE_A);
			forceReset <= 1'b1;
		end else if (state_reg == wdrt_pkg::WDRT_ST_FIRE && pulse_reg == 8'h01) begin
			pulse_reg  <= 8'h00;
			forceReset <= 1'b0;
		end else if (pulse_reg != 8'h00) begin
			pulse_reg <= pulse_reg - 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pcLoad   <= 1'b0;
			bootAddr <= `WDRT_RESET_VECTOR;
		end else begin
			// Reset release lands in the vector state without a transition
			pcLoad   <= state_next == wdrt_pkg::WDRT_ST_VECTOR
				|| (state_reg == wdrt_pkg::WDRT_ST_VECTOR && !pcLoad);
			bootAddr <= `WDRT_RESET_VECTOR;
		end
	end

	// Pin is left to its own pull-up; timer resets stay internal
	assign extRstPinOut = 1'b0;
	assign extRstPinOe  = 1'b0;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence seqFireStart;
		$rose(forceReset);
	endsequence

	sequence seqFireHeld;
		forceReset [*8];
	endsequence

	chk_fire_on_overflow: assert property (overflow && !restartWr |=> forceReset)
		else $error("Overflow did not raise the forced reset");
	chk_fire_pulse_len: assert property (seqFireStart |-> seqFireHeld ##FIRE_TAIL !forceReset)
		else $error("Forced reset pulse has the wrong length");
	chk_restart_clears: assert property (restartWr && !forceReset |=> count_reg == '0 && !forceReset)
		else $error("Restart did not clear the counter");
	chk_defaults_back: assert property (state_reg == wdrt_pkg::WDRT_ST_VECTOR
		|=> enable_reg && !lock_reg && sel_reg == `WDRT_SEL_MAX)
		else $error("Defaults not restored after reset");
	chk_lock_sticks: assert property (lock_reg && state_reg != wdrt_pkg::WDRT_ST_VECTOR |=> lock_reg)
		else $error("Lock dropped without a reset");
	chk_locked_frozen: assert property (lock_reg && state_reg != wdrt_pkg::WDRT_ST_VECTOR
		|=> $stable(enable_reg) && $stable(sel_reg) && enable_reg)
		else $error("Locked configuration changed");
	chk_pin_undriven: assert property (!extRstPinOe)
		else $error("External reset pin driven");
	chk_count_tick_only: assert property (state_reg == wdrt_pkg::WDRT_ST_COUNT && !lfoTick && !restartWr
		|=> $stable(count_reg))
		else $error("Counter moved without an oscillator tick");
	chk_vector_after_fire: assert property ($fell(forceReset) |-> pcLoad && bootAddr == `WDRT_RESET_VECTOR)
		else $error("Fetch restart missing after forced reset");

endmodule : wdrt_timer

/* File: design/wdrt_regs.svh */
// Register map, field positions and timing constants of the supervision timer
`ifndef WDRT_REGS_SVH
`define WDRT_REGS_SVH

`define WDRT_ADDR_W         4
`define WDRT_OFF_CTRL       4'h0
`define WDRT_OFF_RESTART    4'h4
`define WDRT_OFF_STATUS     4'h8

`define WDRT_CTRL_EN_BIT    0
`define WDRT_CTRL_LOCK_BIT  1
`define WDRT_CTRL_SEL_LO    2
`define WDRT_CTRL_SEL_HI    4
`define WDRT_STAT_RUN_BIT   24
`define WDRT_STAT_LOCK_BIT  25
`define WDRT_STAT_FIRE_BIT  26

`define WDRT_SEL_W          3
`define WDRT_SEL_MAX        3'h7
`define WDRT_SEL_SHIFT_MUL  2
`define WDRT_SEL_SHIFT_BASE 6

`define WDRT_RESET_VECTOR   16'h0000
`define WDRT_RESP_OKAY      2'h0
`define WDRT_RESP_SLVERR    2'h2

`define WDRT_CLK_HZ         25000000
`define WDRT_LFO_HZ         80000
`define WDRT_PULSE_NS       400
`define WDRT_CLK_NS         40
`define WDRT_PULSE_CYC      ((`WDRT_PULSE_NS + `WDRT_CLK_NS - 1) / `WDRT_CLK_NS)

`endif

/* File: design/wdrt_pkg.sv */
// Types shared by the supervision timer files
package wdrt_pkg;

	typedef enum logic [3:0] {
		WDRT_ST_VECTOR = 4'h1,
		WDRT_ST_COUNT  = 4'h2,
		WDRT_ST_IDLE   = 4'h4,
		WDRT_ST_FIRE   = 4'h8
	} wdrt_state_type;

endpackage : wdrt_pkg

/* File: design/wdrt_tick_sync.sv */
// Oscillator edge synchroniser producing a one-cycle counting enable
`timescale 1ns/1ps
module wdrt_tick_sync (
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic lowFreqOsc,
	output logic      lfoTick
);

	logic syncA_reg;
	logic syncB_reg;
	logic syncC_reg;

	// First stage feeds only the second one
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			syncA_reg <= 1'b0;
			syncB_reg <= 1'b0;
			syncC_reg <= 1'b0;
		end else begin
			syncA_reg <= lowFreqOsc;
			syncB_reg <= syncA_reg;
			syncC_reg <= syncB_reg;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lfoTick <= 1'b0;
		end else begin
			lfoTick <= syncB_reg & ~syncC_reg;
		end
	end

endmodule : wdrt_tick_sync

/* File: bench/watchdog_reset_timer_tb_top.sv */
// Self-checking bench for the supervision timer
`timescale 1ns/1ps
`include "wdrt_regs.svh"
module watchdog_reset_timer_tb_top;
	logic        ref_clk       = 1'b0;
	logic        arst_n        = 1'b0;
	logic        lowFreqOsc    = 1'b0;
	logic        oscRun        = 1'b1;
	logic [2:0]  oscDiv        = 3'h0;
	logic [3:0]  s_axi_awaddr  = 4'h0;
	logic [3:0]  s_axi_araddr  = 4'h0;
	logic [3:0]  s_axi_wstrb   = 4'hF;
	logic [31:0] s_axi_wdata   = 32'h0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid  = 1'b0;
	logic        s_axi_bready  = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready  = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d, c1;
	logic        forceReset, pcLoad, extRstPinOut, extRstPinOe;
	logic        fireSeen      = 1'b0;
	logic [15:0] bootAddr;
	int          err_total     = 0;
	int          checks        = 0;

	wdrt_timer i_dut (.ref_clk, .arst_n, .lowFreqOsc, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .forceReset, .pcLoad, .bootAddr, .extRstPinOut, .extRstPinOe);

	always #20 ref_clk = ~ref_clk;

	// Fast oscillator, 8 system cycles a period, so short intervals fit the run
	always @(posedge ref_clk) begin
		if (oscRun)
			oscDiv <= oscDiv + 3'h1;
		lowFreqOsc <= oscDiv[2];
		if (forceReset === 1'b1)
			fireSeen <= 1'b1;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	task automatic axi_write(input logic [3:0] addr, input logic [31:0] data);
		@(posedge ref_clk);
		s_axi_awaddr  <= addr;
		s_axi_wdata   <= data;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [3:0] addr);
		@(posedge ref_clk);
		s_axi_araddr  <= addr;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_read

	task automatic wait_fire(input string what);
		int n;
		int len;
		n = 0;
		len = 0;
		while (forceReset !== 1'b1 && n < 3000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		while (forceReset === 1'b1 && len < 50) begin
			check("pin enable", 32'(extRstPinOe), 32'h0);
			check("pin level", 32'(extRstPinOut), 32'h0);
			@(posedge ref_clk);
			#1;
			len++;
		end
		check(what, len, `WDRT_PULSE_CYC);
		check("pcLoad after fire", 32'(pcLoad), 32'h1);
		check("bootAddr after fire", 32'(bootAddr), 32'h0);
	endtask : wait_fire

	task automatic t_reset;
		logic got;
		got = 1'b0;
		repeat (4) begin
			@(posedge ref_clk);
			#1;
			if (pcLoad === 1'b1)
				got = 1'b1;
		end
		check("pcLoad after reset", 32'(got), 32'h1);
		check("bootAddr", 32'(bootAddr), 32'h0);
		axi_read(`WDRT_OFF_CTRL);
		check("ctrl default", d, 32'h1D);
		axi_read(`WDRT_OFF_STATUS);
		check("running default", 32'(d[`WDRT_STAT_RUN_BIT]), 32'h1);
	endtask : t_reset

	task automatic t_bus;
		axi_write(4'hC, 32'h1);
		check("unmapped write resp", 32'(r), 32'h2);
		axi_read(4'hC);
		check("unmapped read resp", 32'(r), 32'h2);
		check("unmapped read data", d, 32'h0);
		axi_write(`WDRT_OFF_STATUS, 32'h0);
		check("status write resp", 32'(r), 32'h2);
		axi_read(`WDRT_OFF_RESTART);
		check("restart reads zero", d, 32'h0);
	endtask : t_bus

	task automatic t_restart;
		axi_write(`WDRT_OFF_CTRL, 32'h1);
		check("ctrl write resp", 32'(r), 32'h0);
		fireSeen = 1'b0;
		// Restart every 40 ticks; the 64-tick interval is never reached
		repeat (6) begin
			repeat (320) @(posedge ref_clk);
			axi_write(`WDRT_OFF_RESTART, 32'h0);
		end
		check("no fire with restarts", 32'(fireSeen), 32'h0);
		oscRun <= 1'b0;
		repeat (20) @(posedge ref_clk);
		axi_read(`WDRT_OFF_STATUS);
		c1 = d & 32'hFFFFF;
		repeat (200) @(posedge ref_clk);
		axi_read(`WDRT_OFF_STATUS);
		check("count frozen", d & 32'hFFFFF, c1);
		oscRun <= 1'b1;
		repeat (100) @(posedge ref_clk);
		axi_read(`WDRT_OFF_STATUS);
		check("count moves", 32'((d & 32'hFFFFF) > c1), 32'h1);
		axi_write(`WDRT_OFF_CTRL, 32'h0);
		fireSeen = 1'b0;
		repeat (800) @(posedge ref_clk);
		check("no fire when off", 32'(fireSeen), 32'h0);
		axi_read(`WDRT_OFF_STATUS);
		check("stopped", 32'(d[`WDRT_STAT_RUN_BIT]), 32'h0);
	endtask : t_restart

	task automatic t_lock;
		axi_write(`WDRT_OFF_CTRL, 32'h2);
		axi_read(`WDRT_OFF_CTRL);
		check("locked ctrl", d, 32'h3);
		axi_write(`WDRT_OFF_CTRL, 32'h1C);
		check("locked write resp", 32'(r), 32'h0);
		axi_read(`WDRT_OFF_CTRL);
		check("ctrl unchanged", d, 32'h3);
		axi_read(`WDRT_OFF_STATUS);
		check("lock flag", 32'(d[`WDRT_STAT_LOCK_BIT]), 32'h1);
		wait_fire("forced reset length");
		axi_read(`WDRT_OFF_CTRL);
		check("ctrl after fire", d, 32'h1D);
	endtask : t_lock

	task automatic complete_run;
		$display("checks %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	initial begin
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_reset();
		t_bus();
		t_restart();
		t_lock();
		complete_run();
	end

	// Whole sequence needs about 3700 cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		complete_run();
	end
endmodule : watchdog_reset_timer_tb_top
